// file: rtl/pxs_defs.vh
// pxs_defs.vh: register map, field positions, reset values, timing counts
// assumes a 50 MHz mclk and byte-wide register access from a serial slave
`ifndef PXS_DEFS_VH
`define PXS_DEFS_VH

// register offsets
`define PXS_ADDR_MODE_CTRL 8'h00
`define PXS_ADDR_SENS_CFG 8'h01
`define PXS_ADDR_RES_LO 8'h02
`define PXS_ADDR_RES_HI 8'h03
`define PXS_ADDR_LT_LO 8'h04
`define PXS_ADDR_LT_HI 8'h05
`define PXS_ADDR_UT_LO 8'h06
`define PXS_ADDR_UT_HI 8'h07

// mode_and_alarm_control fields
`define PXS_OPM_HI 7
`define PXS_OPM_LO 5
`define PXS_FLAG_BIT 2
`define PXS_PRST_HI 1
`define PXS_PRST_LO 0

// sensing_config fields
`define PXS_SCHEME_BIT 7
`define PXS_MODSEL_BIT 6
`define PXS_ISEL_HI 5
`define PXS_ISEL_LO 4
`define PXS_RES_HI 3
`define PXS_RES_LO 2
`define PXS_FSR_HI 1
`define PXS_FSR_LO 0

// reset values
`define PXS_RST_MODE_CTRL 8'h00
`define PXS_RST_SENS_CFG 8'h00
`define PXS_RST_RESULT 16'h0000
`define PXS_RST_LT 8'h00
`define PXS_RST_UT 8'hFF

// operating mode codes
`define PXS_OPM_DOWN 3'h0
`define PXS_OPM_IR_ONCE 3'h2
`define PXS_OPM_PX_ONCE 3'h3
`define PXS_OPM_IR_CONT 3'h6
`define PXS_OPM_PX_CONT 3'h7

// timing
`define PXS_CLK_EMITTER_MODULATION_SELECT_KHZ 50000
`define PXS_OSC_EMITTER_MODULATION_SELECT_KHZ 725
`define PXS_MOD_EMITTER_MODULATION_SELECT_KHZ 360
`define PXS_OSC_DIV (`PXS_CLK_EMITTER_MODULATION_SELECT_KHZ / `PXS_OSC_EMITTER_MODULATION_SELECT_KHZ)
`define PXS_MOD_HALF_CYC (`PXS_CLK_EMITTER_MODULATION_SELECT_KHZ / (2 * `PXS_MOD_EMITTER_MODULATION_SELECT_KHZ))

`endif

// file: rtl/pxs_emit_drv.v
// pxs_emit_drv: emitter driver switch, steady or 360 kHz square wave
// assumes mclk at 50 MHz; enable comes from the conversion sequencer
`timescale 1ns/1ps
`include "pxs_defs.vh"

module pxs_emit_drv (
  input wire mclk,
  input wire sys_rst,
  input wire drive_en,
  input wire modulate,
  output wire emitter_drive_pin
);

localparam integer HALF_CYC_N = `PXS_MOD_HALF_CYC;
localparam [6:0] HALF_CYC = HALF_CYC_N[6:0];

reg [6:0] div_ff;
reg phase_ff;
reg pin_ff;

////////////////////////////////////////////////////////////////////////////
// half-period divider, restarts with each enable so every burst starts high
always @(posedge mclk) begin
  if (sys_rst || !drive_en) begin
    div_ff <= 7'h00;
    phase_ff <= 1'b1;
  end else if (div_ff == HALF_CYC - 7'h01) begin
    div_ff <= 7'h00;
    phase_ff <= ~phase_ff;
  end else begin
    div_ff <= div_ff + 7'h01;
  end
end

always @(posedge mclk) begin
  if (sys_rst) begin
    pin_ff <= 1'b0;
  end else begin
    pin_ff <= drive_en & (modulate ? phase_ff : 1'b1); // RQ3
  end
end

assign emitter_drive_pin = pin_ff;

endmodule // pxs_emit_drv

// file: rtl/pxs_persist.v
// pxs_persist: threshold window check and consecutive-out counter
// assumes conv_done is one cycle wide and result is valid with it
`timescale 1ns/1ps
`include "pxs_defs.vh"

module pxs_persist (
  input wire mclk,
  input wire sys_rst,
  input wire restart,
  input wire conv_done,
  input wire [15:0] result,
  input wire [15:0] lower_threshold_bits,
  input wire [15:0] upper_threshold_bits,
  input wire [1:0] persist_sel,
  output wire hit
);

reg [4:0] cnt_ff;
reg hit_ff;
reg [4:0] need;
wire outside;

////////////////////////////////////////////////////////////////////////////
// strict compare, both edges of the window count as inside
assign outside = (result < lower_threshold_bits) || (result > upper_threshold_bits); // RQ18

always @* begin
  case (persist_sel) // RQ14
    2'h0: need = 5'h01;
    2'h1: need = 5'h04;
    2'h2: need = 5'h08;
    default: need = 5'h10;
  endcase
end

// counter saturates at the target so a long excursion keeps hitting
always @(posedge mclk) begin
  if (sys_rst || restart) begin
    cnt_ff <= 5'h00; // RQ17
    hit_ff <= 1'b0;
  end else if (conv_done) begin
    if (!outside) begin
      cnt_ff <= 5'h00;
      hit_ff <= 1'b0;
    end else if (cnt_ff + 5'h01 >= need) begin
      cnt_ff <= need;
      hit_ff <= 1'b1; // RQ14
    end else begin
      cnt_ff <= cnt_ff + 5'h01;
      hit_ff <= 1'b0;
    end
  end else begin
    hit_ff <= 1'b0;
  end
end

assign hit = hit_ff;

endmodule // pxs_persist

// file: rtl/pxs_core.v
// pxs_core: configuration, result and threshold registers of the sensor
// assumes a serial slave delivers byte reads and writes on the reg_* port,
// and an analog front end reports its counts at the end of integration.
//
// Contract
// RQ1 - scheme bit 1 gives ambient-subtracted signed proximity, one bit narrower
// RQ2 - signed proximity count clamps to plus/minus two to the n-1; code stops the top at 2^(n-1)-1 and reads values below -2^(n-1) as zero
// RQ3 - modulation bit: 0 steady emitter drive, 1 square wave at 360 kHz
// RQ4 - two-bit current field selects 12.5, 25, 50 or 100 mA drive
// RQ5 - resolution field: 16/12/8/4 bits with matching oscillator cycle counts
// RQ6 - integration lasts two to the n oscillator cycles
// RQ7 - range field codes 00 to 11 select ranges one to four
// RQ8 - result bytes at 02 and 03 are read-only, writes ignored
// RQ9 - result is right-aligned at bit zero, width follows resolution
// RQ10 - both result bytes refresh at the end of every conversion
// RQ11 - lower threshold at 04/05, resets to 00
// RQ12 - upper threshold at 06/07, resets to FF
// RQ13 - internal oscillator nominally 725 kHz, sets conversion timing
// RQ14 - alarm raised after m consecutive out-of-window conversions, m 1/4/8/16
// RQ15 - alarm pin low and flag set until host transfers to mode register
// RQ16 - three-bit mode: down, infrared/proximity, once or continuous
// RQ17 - persistence counter clears whenever the operating mode changes
// RQ18 - out of window means strictly below lower or above upper
`timescale 1ns/1ps
`include "pxs_defs.vh"

module pxs_core (
  input wire mclk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [7:0] reg_rdata,
  output wire reg_rvalid,
  input wire [15:0] afe_total,
  input wire [15:0] afe_ambient,
  output wire integ_active,
  output wire prox_phase,
  output wire conv_done,
  output wire emitter_drive_pin,
  output wire emitter_current_sel_hi,
  output wire emitter_current_sel_lo,
  output wire fullscale_sel_hi,
  output wire fullscale_sel_lo,
  output wire alarm_pin_o,
  output wire alarm_pin_oe,
  output wire alarm_flag
);

////////////////////////////////////////////////////////////////////////////
// declarations

localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_INTEG = 2'h1;
localparam [1:0] ST_DONE = 2'h2;

localparam integer OSC_DIV_N = `PXS_OSC_DIV;
localparam [6:0] OSC_DIV = OSC_DIV_N[6:0];
reg [7:0] mode_ctrl_ff;
reg [7:0] sens_cfg_ff;
reg [15:0] result_ff;
reg [7:0] lt_lo_ff;
reg [7:0] lt_hi_ff;
reg [7:0] ut_lo_ff;
reg [7:0] ut_hi_ff;
reg flag_ff;
reg alarm_oe_ff;
reg alarm_o_ff;
reg [7:0] rdata_ff;
reg rvalid_ff;
reg [1:0] state_ff;
reg [1:0] nxt_state;
reg [6:0] osc_div_ff;
reg osc_tick_ff;
reg [16:0] tick_cnt_ff;
reg integ_ff;
reg prox_ff;
reg done_ff;
reg start_ff;
reg mode_chg_ff;
reg [7:0] nxt_rdata;
reg [15:0] full_mask;
reg [15:0] conv_value;

wire wr_mode;
wire [2:0] opm;
wire [2:0] new_opm;
wire run_mode;
wire cont_mode;
wire prox_mode;
wire [16:0] last_tick;
wire [16:0] diff;
wire [16:0] pos_lim;
wire [16:0] neg_lim;
wire [15:0] half_mask;
wire persist_hit;
wire nxt_flag;
wire end_integ;

////////////////////////////////////////////////////////////////////////////
// mode decode

assign opm = mode_ctrl_ff[`PXS_OPM_HI:`PXS_OPM_LO];
assign new_opm = reg_wdata[`PXS_OPM_HI:`PXS_OPM_LO];
assign wr_mode = reg_wr && (reg_addr == `PXS_ADDR_MODE_CTRL);
// reserved codes 001, 100, 101 have bit 1 clear and behave as power-down
assign run_mode = opm[1]; // RQ16
assign cont_mode = opm[2]; // RQ16
assign prox_mode = opm[0]; // RQ16

////////////////////////////////////////////////////////////////////////////
// register writes

always @(posedge mclk) begin
  if (sys_rst) begin
    mode_ctrl_ff <= `PXS_RST_MODE_CTRL;
    sens_cfg_ff <= `PXS_RST_SENS_CFG;
    lt_lo_ff <= `PXS_RST_LT; // RQ11
    lt_hi_ff <= `PXS_RST_LT; // RQ11
    ut_lo_ff <= `PXS_RST_UT; // RQ12
    ut_hi_ff <= `PXS_RST_UT; // RQ12
  end else if (reg_wr) begin
    // result bytes have no write path at all
    case (reg_addr) // RQ8
      `PXS_ADDR_MODE_CTRL: begin
        // flag bit is status only, bits 4:3 stay zero
        mode_ctrl_ff <= {new_opm, 3'h0, reg_wdata[`PXS_PRST_HI:`PXS_PRST_LO]};
      end
      `PXS_ADDR_SENS_CFG: sens_cfg_ff <= reg_wdata;
      `PXS_ADDR_LT_LO: lt_lo_ff <= reg_wdata; // RQ11
      `PXS_ADDR_LT_HI: lt_hi_ff <= reg_wdata; // RQ11
      `PXS_ADDR_UT_LO: ut_lo_ff <= reg_wdata; // RQ12
      `PXS_ADDR_UT_HI: ut_hi_ff <= reg_wdata; // RQ12
      default: begin
      end
    endcase
  end
end

// a mode-register write with a running code starts a fresh run from idle or done, an ongoing integration keeps its tick count; a changed code also
// restarts persistence, thresholds are software's to reload
always @(posedge mclk) begin
  if (sys_rst) begin
    start_ff <= 1'b0;
    mode_chg_ff <= 1'b0;
  end else begin
    start_ff <= wr_mode;
    mode_chg_ff <= wr_mode && (new_opm != opm); // RQ17
  end
end

////////////////////////////////////////////////////////////////////////////
// internal oscillator tick, a divided mclk standing in for the resistor-set
// oscillator; a different resistor means a different OSC_DIV

always @(posedge mclk) begin
  if (sys_rst || osc_div_ff == OSC_DIV - 7'h01) begin
    osc_div_ff <= 7'h00;
  end else begin
    osc_div_ff <= osc_div_ff + 7'h01;
  end
end

always @(posedge mclk) begin
  if (sys_rst) begin
    osc_tick_ff <= 1'b0;
  end else begin
    osc_tick_ff <= (osc_div_ff == OSC_DIV - 7'h01); // RQ13
  end
end

////////////////////////////////////////////////////////////////////////////
// resolution decode

always @* begin
  case (sens_cfg_ff[`PXS_RES_HI:`PXS_RES_LO]) // RQ5
    2'h0: full_mask = 16'hFFFF;
    2'h1: full_mask = 16'h0FFF;
    2'h2: full_mask = 16'h00FF;
    default: full_mask = 16'h000F;
  endcase
end

// 2^n - 1 ticks counted from zero gives 2^n oscillator cycles
assign last_tick = {1'b0, full_mask}; // RQ6
assign end_integ = osc_tick_ff && (tick_cnt_ff == last_tick); // RQ6

////////////////////////////////////////////////////////////////////////////
// conversion sequencer

always @* begin
  nxt_state = state_ff;
  case (state_ff)
    ST_IDLE: begin
      if (start_ff && run_mode) begin
        nxt_state = ST_INTEG;
      end
    end
    ST_INTEG: begin
      if (end_integ) begin
        nxt_state = ST_DONE;
      end
    end
    ST_DONE: begin
      // once modes drop back to idle, the result stays readable
      nxt_state = (run_mode && cont_mode) ? ST_INTEG : ST_IDLE; // RQ16
    end
    default: nxt_state = ST_IDLE;
  endcase
  if (start_ff && !run_mode) begin
    nxt_state = ST_IDLE; // RQ16
  end else if (start_ff) begin
    nxt_state = ST_INTEG;
  end
end

always @(posedge mclk) begin
  if (sys_rst) begin
    state_ff <= ST_IDLE;
  end else begin
    state_ff <= nxt_state;
  end
end

always @(posedge mclk) begin
  if (sys_rst || nxt_state != ST_INTEG || state_ff != ST_INTEG) begin
    tick_cnt_ff <= 17'h00000;
  end else if (osc_tick_ff) begin
    tick_cnt_ff <= tick_cnt_ff + 17'h00001; // RQ6
  end
end

always @(posedge mclk) begin
  if (sys_rst) begin
    integ_ff <= 1'b0;
    prox_ff <= 1'b0;
    done_ff <= 1'b0;
  end else begin
    integ_ff <= (nxt_state == ST_INTEG);
    prox_ff <= (nxt_state == ST_INTEG) && prox_mode; // RQ3
    done_ff <= (state_ff == ST_INTEG) && (nxt_state == ST_DONE);
  end
end

////////////////////////////////////////////////////////////////////////////
// result formatting

assign half_mask = {1'b0, full_mask[15:1]};
assign diff = {1'b0, afe_total} - {1'b0, afe_ambient}; // RQ1
assign pos_lim = {1'b0, half_mask}; // RQ2
assign neg_lim = ~{1'b0, half_mask}; // RQ2

always @* begin
  conv_value = afe_total;
  if (prox_mode && sens_cfg_ff[`PXS_SCHEME_BIT]) begin
    // signed n-1 bit count; the top code saturates one short of +2^(n-1)
    if ($signed(diff) > $signed(pos_lim)) begin
      conv_value = half_mask; // RQ2
    end else if ($signed(diff) < $signed(neg_lim)) begin
      conv_value = neg_lim[15:0] & half_mask; // RQ2
    end else begin
      conv_value = diff[15:0] & half_mask; // RQ1
    end
  end else if (afe_total > full_mask) begin
    // reserved scheme 0 and infrared modes give an unsigned n-bit count
    conv_value = full_mask; // RQ9
  end else begin
    conv_value = afe_total & full_mask; // RQ9
  end
end

always @(posedge mclk) begin
  if (sys_rst) begin
    result_ff <= `PXS_RST_RESULT;
  end else if (state_ff == ST_INTEG && end_integ) begin
    result_ff <= conv_value; // RQ10
  end
end

////////////////////////////////////////////////////////////////////////////
// interrupt persistence and alarm

pxs_persist u_persist (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .restart(mode_chg_ff),
  .conv_done(done_ff),
  .result(result_ff),
  .lower_threshold_bits({lt_hi_ff, lt_lo_ff}),
  .upper_threshold_bits({ut_hi_ff, ut_lo_ff}),
  .persist_sel(mode_ctrl_ff[`PXS_PRST_HI:`PXS_PRST_LO]),
  .hit(persist_hit)
);

// a hit in the same cycle as the clearing transfer keeps the flag set
assign nxt_flag = persist_hit | (flag_ff & ~wr_mode); // RQ15

always @(posedge mclk) begin
  if (sys_rst) begin
    flag_ff <= 1'b0;
    alarm_oe_ff <= 1'b0;
    alarm_o_ff <= 1'b0;
  end else begin
    flag_ff <= nxt_flag; // RQ15
    alarm_oe_ff <= nxt_flag; // RQ15
    alarm_o_ff <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////
// register reads

always @* begin
  case (reg_addr)
    `PXS_ADDR_MODE_CTRL: begin
      nxt_rdata = {opm, 2'h0, flag_ff, mode_ctrl_ff[`PXS_PRST_HI:`PXS_PRST_LO]};
    end
    `PXS_ADDR_SENS_CFG: nxt_rdata = sens_cfg_ff;
    `PXS_ADDR_RES_LO: nxt_rdata = result_ff[7:0]; // RQ8
    `PXS_ADDR_RES_HI: nxt_rdata = result_ff[15:8]; // RQ8
    `PXS_ADDR_LT_LO: nxt_rdata = lt_lo_ff;
    `PXS_ADDR_LT_HI: nxt_rdata = lt_hi_ff;
    `PXS_ADDR_UT_LO: nxt_rdata = ut_lo_ff;
    `PXS_ADDR_UT_HI: nxt_rdata = ut_hi_ff;
    default: nxt_rdata = 8'h00;
  endcase
end

always @(posedge mclk) begin
  if (sys_rst) begin
    rdata_ff <= 8'h00;
    rvalid_ff <= 1'b0;
  end else begin
    rvalid_ff <= reg_rd;
    if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// emitter driver

pxs_emit_drv u_emit (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .drive_en(prox_ff),
  .modulate(sens_cfg_ff[`PXS_MODSEL_BIT]),
  .emitter_drive_pin(emitter_drive_pin)
);

////////////////////////////////////////////////////////////////////////////
// outputs; current level and range are analog settings taken from flops

assign reg_rdata = rdata_ff;
assign reg_rvalid = rvalid_ff;
assign integ_active = integ_ff;
assign prox_phase = prox_ff;
assign conv_done = done_ff;
assign emitter_current_sel_hi = sens_cfg_ff[`PXS_ISEL_HI]; // RQ4
assign emitter_current_sel_lo = sens_cfg_ff[`PXS_ISEL_LO]; // RQ4
assign fullscale_sel_hi = sens_cfg_ff[`PXS_FSR_HI]; // RQ7
assign fullscale_sel_lo = sens_cfg_ff[`PXS_FSR_LO]; // RQ7
assign alarm_pin_o = alarm_o_ff;
assign alarm_pin_oe = alarm_oe_ff;
assign alarm_flag = flag_ff;

endmodule // pxs_core

// file: sim/pxs_core_sva.sv
// pxs_core_sva: port-level checks of the register, conversion and alarm behaviour
// assumes it is bound into pxs_core, one clock mclk, synchronous sys_rst
`timescale 1ns/1ps
module pxs_core_sva (
  input wire mclk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire reg_rvalid,
  input wire integ_active,
  input wire prox_phase,
  input wire conv_done,
  input wire emitter_drive_pin,
  input wire emitter_current_sel_hi,
  input wire emitter_current_sel_lo,
  input wire fullscale_sel_hi,
  input wire fullscale_sel_lo,
  input wire alarm_pin_o,
  input wire alarm_pin_oe,
  input wire alarm_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire wr_mode = reg_wr && reg_addr == 8'h00;
  wire wr_cfg = reg_wr && reg_addr == 8'h01;
  reg [7:0] cfg_ff;
  // shadow of the last config byte, so pin mirrors can be judged
  always @(posedge mclk) begin
    if (sys_rst)
      cfg_ff <= 8'h00;
    else if (wr_cfg)
      cfg_ff <= reg_wdata;
  end
  ////////////////////////////////////////////////////////////////
  rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  rdata_hold_a: assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("read data moved");
  conv_pulse_a: assert property (conv_done |=> !conv_done) else $error("done not a pulse");
  done_idle_a: assert property (conv_done |-> !integ_active) else $error("done while integrating");
  alarm_pin_a: assert property (alarm_pin_oe == alarm_flag && !alarm_pin_o) else $error("alarm pin wrong");
  flag_rise_a: assert property ($rose(alarm_flag) |-> $past(conv_done, 2)) else $error("flag without result");
  flag_clear_a: assert property (wr_mode && !$past(conv_done) |=> !alarm_flag) else $error("flag not cleared");
  flag_hold_a: assert property (alarm_flag && !wr_mode |=> alarm_flag) else $error("flag dropped");
  drive_sel_a: assert property (!wr_cfg && !$past(wr_cfg)
    |-> {emitter_current_sel_hi, emitter_current_sel_lo} == cfg_ff[5:4]) else $error("current select wrong");
  range_sel_a: assert property (!wr_cfg && !$past(wr_cfg)
    |-> {fullscale_sel_hi, fullscale_sel_lo} == cfg_ff[1:0]) else $error("range select wrong");
  emit_idle_a: assert property (!prox_phase && !$past(prox_phase) && !$past(prox_phase, 2)
    |-> !emitter_drive_pin) else $error("emitter on outside proximity");
endmodule // pxs_core_sva
bind pxs_core pxs_core_sva u_pxs_core_sva (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .integ_active(integ_active), .prox_phase(prox_phase), .conv_done(conv_done),
  .emitter_drive_pin(emitter_drive_pin), .emitter_current_sel_hi(emitter_current_sel_hi),
  .emitter_current_sel_lo(emitter_current_sel_lo), .fullscale_sel_hi(fullscale_sel_hi),
  .fullscale_sel_lo(fullscale_sel_lo), .alarm_pin_o(alarm_pin_o), .alarm_pin_oe(alarm_pin_oe),
  .alarm_flag(alarm_flag));

// file: sim/pxs_host.sv
// pxs_host: byte-level host model standing in for the serial bus controller
// assumes strobes are sampled on rising mclk; drives at falling edges
`timescale 1ns/1ps
module pxs_host (
  input wire mclk,
  input wire [7:0] reg_rdata,
  input wire reg_rvalid,
  output reg [7:0] reg_addr,
  output reg [7:0] reg_wdata,
  output reg reg_wr,
  output reg reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // strobe edge is the end of the byte transfer
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(negedge mclk);
      reg_wr <= 1'b0;
      // released lines wander rather than hold the old value
      reg_wdata <= ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(negedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(negedge mclk);
      reg_rd <= 1'b0;
      d = reg_rvalid ? reg_rdata : {8{1'bx}};
    end
  endtask
endmodule // pxs_host

// file: sim/pxs_core_tb.sv
// pxs_core_tb: self-checking bench for pxs_core
// assumes pxs_host drives the register port; bench drives the front-end counts
`timescale 1ns/1ps
module pxs_core_tb;
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg [15:0] afe_total = 16'h0000;
  reg [15:0] afe_ambient = 16'h0000;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, reg_rvalid, integ_active, prox_phase, conv_done, drv;
  wire cur_hi, cur_lo, fs_hi, fs_lo, alarm_pin_o, alarm_pin_oe, alarm_flag;
  integer n_errors = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer edges, base, i;
  integer lowc = 0;
  reg [7:0] rb;
  initial forever #10 mclk = ~mclk;
  pxs_host u_pxs_host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  pxs_core u_pxs_core (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .afe_total(afe_total),
    .afe_ambient(afe_ambient), .integ_active(integ_active), .prox_phase(prox_phase), .conv_done(conv_done),
    .emitter_drive_pin(drv), .emitter_current_sel_hi(cur_hi), .emitter_current_sel_lo(cur_lo),
    .fullscale_sel_hi(fs_hi), .fullscale_sel_lo(fs_lo), .alarm_pin_o(alarm_pin_o),
    .alarm_pin_oe(alarm_pin_oe), .alarm_flag(alarm_flag));
  // about 29k cycles of conversions expected, the 8-bit run dominates
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (prox_phase === 1'b1 && drv === 1'b0)
      lowc <= lowc + 1;
    if (cyc == 40000) begin
      n_errors = n_errors + 1;
      complete_run;
    end
  end
  ////////////////////////////////////////////////////////////////
  task complete_run;
    begin
      $display("compares %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task rdchk(input [7:0] a, input [15:0] exp);
    begin
      u_pxs_host.rd(a, rb);
      chk({8'h00, rb}, exp);
    end
  endtask
  // bounded wait for the end of a conversion; edges counts the wait
  task wait_done;
    begin
      edges = 0;
      while (conv_done !== 1'b1 && edges < 20000) begin
        @(negedge mclk);
        edges = edges + 1;
      end
      chk(conv_done, 1);
      @(negedge mclk);
    end
  endtask
  task flag_after(input [15:0] exp);
    begin
      repeat (2) @(negedge mclk);
      chk(alarm_flag, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task t_regs;
    begin
      rdchk(8'h04, 16'h0000);
      rdchk(8'h05, 16'h0000);
      rdchk(8'h06, 16'h00FF);
      rdchk(8'h07, 16'h00FF);
      u_pxs_host.wr(8'h04, 8'h5A);
      u_pxs_host.wr(8'h07, 8'h3C);
      u_pxs_host.wr(8'h02, 8'hA5);
      u_pxs_host.wr(8'h03, 8'hA5);
      rdchk(8'h04, 16'h005A);
      rdchk(8'h07, 16'h003C);
      rdchk(8'h02, 16'h0000);
      rdchk(8'h03, 16'h0000);
      for (i = 0; i < 4; i = i + 1) begin
        u_pxs_host.wr(8'h01, {2'b10, i[1:0], 2'b00, i[1:0]});
        repeat (3) @(negedge mclk);
        chk({cur_hi, cur_lo}, i[1:0]);
        chk({fs_hi, fs_lo}, i[1:0]);
      end
      u_pxs_host.wr(8'h04, 8'h00);
      u_pxs_host.wr(8'h07, 8'hFF);
      $display("test registers done");
    end
  endtask
  task t_ir;
    begin
      afe_total = 16'h0123;
      u_pxs_host.wr(8'h01, 8'h8C);
      u_pxs_host.wr(8'h00, 8'h40);
      wait_done;
      chk(edges >= 68 * 15 && edges <= 68 * 17 + 4, 1);
      rdchk(8'h02, 16'h000F);
      rdchk(8'h03, 16'h0000);
      chk(integ_active, 0);
      $display("test infrared once done");
    end
  endtask
  task t_prox;
    begin
      afe_total = 16'h0030;
      afe_ambient = 16'h0010;
      u_pxs_host.wr(8'h01, 8'hCC);
      base = lowc;
      u_pxs_host.wr(8'h00, 8'h60);
      wait_done;
      rdchk(8'h02, 16'h0007);
      chk(lowc - base > 300, 1);
      afe_total = 16'h0010;
      afe_ambient = 16'h0013;
      u_pxs_host.wr(8'h01, 8'h8C);
      base = lowc;
      u_pxs_host.wr(8'h00, 8'h60);
      wait_done;
      rdchk(8'h02, 16'h0005);
      rdchk(8'h03, 16'h0000);
      chk(lowc - base < 4, 1);
      $display("test proximity done");
    end
  endtask
  task t_alarm;
    begin
      u_pxs_host.wr(8'h04, 8'h05);
      afe_total = 16'h0005;
      u_pxs_host.wr(8'h00, 8'hC0);
      wait_done;
      wait_done;
      flag_after(0);
      afe_total = 16'h0000;
      wait_done;
      flag_after(1);
      chk(alarm_pin_oe, 1);
      rdchk(8'h00, 16'h00C4);
      // reserved code powers down and changes mode, so the count restarts
      u_pxs_host.wr(8'h00, 8'h21);
      @(negedge mclk);
      chk(alarm_flag, 0);
      u_pxs_host.wr(8'h00, 8'hC1);
      wait_done;
      wait_done;
      wait_done;
      flag_after(0);
      wait_done;
      flag_after(1);
      u_pxs_host.wr(8'h00, 8'h00);
      @(negedge mclk);
      chk(alarm_flag, 0);
      $display("test alarm done");
    end
  endtask
  // 8-bit continuous proximity, positive clamp, then stopped by power-down
  task t_res8;
    begin
      afe_total = 16'h0300;
      afe_ambient = 16'h0100;
      u_pxs_host.wr(8'h01, 8'h88);
      u_pxs_host.wr(8'h00, 8'hE0);
      wait_done;
      chk(edges >= 68 * 255 && edges <= 68 * 257 + 4, 1);
      rdchk(8'h02, 16'h007F);
      rdchk(8'h03, 16'h0000);
      u_pxs_host.wr(8'h00, 8'h00);
      repeat (2) @(negedge mclk);
      chk(integ_active, 0);
      $display("test eight-bit proximity continuous done");
    end
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    t_regs;
    t_ir;
    t_prox;
    t_alarm;
    t_res8;
    complete_run;
  end
endmodule // pxs_core_tb
